// *** chl_defines.svh ***
/*
 * constants of the ascii command parser: control characters, command codes,
 * register offsets, reset values and setpoint limits.
 * assumes it is included by bare name ahead of the modules that use its macros.
 */
// Functional notes
// - sensor and offset replies carry a hundredths digit, 0.01 degree resolution.
// - negative temperature replies put the minus character 2DH in the tens position.
// - each alarm character encodes one alarm bit group, one means active.
// - an alarm character carries the sum of the weights of its active bits.
// - alarm read 34 replies STX, command, three alarm characters, ETX, checksum, CR.
// - volatile offset write is not stored in nonvolatile memory, 0.01 degree resolution.
// - offset sign position is 2DH for negative and 30H for positive.
// - offset read 36 replies sign, ones, tenths, hundredths inside the usual frame.
// - setpoint write 37H is applied and also written to nonvolatile memory.
// - nonvolatile setpoint accepts only 10.0 to 60.0 degrees in tenth steps.
// - a nonzero hundredths digit of a nonvolatile setpoint is rounded to a tenth.
// - offset write 38H is applied and stored in nonvolatile memory.
// - unit character is 30H plus unit number and is echoed in replies.
// - setpoint read 31 replies four digits tens to hundredths in the frame.
// - external sensor read 33 replies four digits in the frame.
// - unit-specified write 31 accepted by addressed unit only, answered ACK, unit, CR.
`ifndef CHL_DEFINES_SVH
`define CHL_DEFINES_SVH
// control characters
`define CHL_SOH 8'h01
`define CHL_STX 8'h02
`define CHL_ETX 8'h03
`define CHL_ENQ 8'h05
`define CHL_ACK 8'h06
`define CHL_CR 8'h0D
`define CHL_MINUS 8'h2D
`define CHL_ZERO 8'h30
`define CHL_HI 4'h3
// command characters
`define CHL_CMD_SETP 8'h31
`define CHL_CMD_INT 8'h32
`define CHL_CMD_EXT 8'h33
`define CHL_CMD_ALM 8'h34
`define CHL_CMD_OFS 8'h36
`define CHL_CMD_NVSETP 8'h37
`define CHL_CMD_NVOFS 8'h38
// wishbone byte offsets
`define CHL_REG_CTRL 8'h00
`define CHL_REG_SETP 8'h04
`define CHL_REG_OFS 8'h08
`define CHL_REG_ISTAT 8'h0C
`define CHL_REG_ICLR 8'h10
`define CHL_REG_IEN 8'h14
`define CHL_REG_STATE 8'h18
// reset values: parser enabled, unit 1, setpoint 25.00
`define CHL_CTRL_RST 8'h11
`define CHL_SETP_RST 16'h2500
`define CHL_SETP_MIN 16'h1000
`define CHL_SETP_MAX 16'h6000
// interrupt bits
`define CHL_IRQ_W 3
`define CHL_IRQ_DONE 0
`define CHL_IRQ_DROP 1
`define CHL_IRQ_NVWR 2
`endif

// *** chl_pkg.sv ***
/*
 * types shared by the ascii command parser and its reply framer.
 * assumes nothing beyond a systemverilog compiler.
 */
package chl_pkg;
   // temperature as bcd digits, sign separate
   typedef struct packed {
      logic neg;
      logic [3:0] tens;
      logic [3:0] ones;
      logic [3:0] tenths;
      logic [3:0] hund;
   } chl_temp_s;
   // offset as sign and three bcd digits
   typedef struct packed {
      logic neg;
      logic [3:0] ones;
      logic [3:0] tenths;
      logic [3:0] hund;
   } chl_ofs_s;
   // one reply for the framer; data[0] goes out first
   typedef struct packed {
      logic unit_spec;
      logic [7:0] unit_char;
      logic is_ack;
      logic [7:0] cmd;
      logic [2:0] n_data;
      logic [3:0][7:0] data;
   } chl_reply_s;
   typedef enum logic [3:0] {
      RX_IDLE, RX_UNIT, RX_LEAD, RX_CMD, RX_DATA, RX_ETX, RX_SUMH, RX_SUML, RX_END, RX_SKIP
   } chl_rx_e;
endpackage : chl_pkg

// *** chl_tx_frame.sv ***
/*
 * reply framer: builds a whole reply frame, with checksum for data replies, when started and
 * shifts it out one byte per accepted transfer.
 * assumes the sink takes a byte when valid and ready are both high.
 */
`include "chl_defines.svh"
module chl_tx_frame (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_b_i,
   // reply request
   input wire logic start_i,
   input chl_pkg::chl_reply_s req_i,
   output logic busy_o,
   // byte stream out
   output logic tx_valid_o,
   input wire logic tx_ready_i,
   output logic [7:0] tx_data_o
);
   import chl_pkg::*;
   logic [11:0][7:0] frm_q, frm_d;
   logic [3:0] len_q, len_d, p;
   logic [7:0] sum;

   // frame assembly on start, shift on each accepted byte
   always_comb begin
      frm_d = frm_q;
      len_d = len_q;
      p = 4'd0;
      sum = 8'h00;
      if (len_q == 4'd0) begin
         if (start_i) begin
            frm_d = '0;
            if (req_i.is_ack) begin
               frm_d[p] = `CHL_ACK;
               p = p + 4'd1;
               if (req_i.unit_spec) begin
                  frm_d[p] = req_i.unit_char;
                  p = p + 4'd1;
               end
            end else begin
               if (req_i.unit_spec) begin
                  frm_d[p] = `CHL_SOH;
                  frm_d[p + 4'd1] = req_i.unit_char;
                  p = p + 4'd2;
                  sum = req_i.unit_char + `CHL_STX;
               end
               frm_d[p] = `CHL_STX;
               frm_d[p + 4'd1] = req_i.cmd;
               p = p + 4'd2;
               sum = sum + req_i.cmd;
               for (int i = 0; i < 4; i++) begin
                  if (3'(i) < req_i.n_data) begin
                     frm_d[p] = req_i.data[i];
                     p = p + 4'd1;
                     sum = sum + req_i.data[i];
                  end
               end
               frm_d[p] = `CHL_ETX;
               frm_d[p + 4'd1] = {`CHL_HI, sum[7:4]};
               frm_d[p + 4'd2] = {`CHL_HI, sum[3:0]};
               p = p + 4'd3;
            end
            frm_d[p] = `CHL_CR;
            len_d = p + 4'd1;
         end
      end else if (tx_ready_i) begin
         frm_d = frm_q >> 8;
         len_d = len_q - 4'd1;
      end
   end

   // frame store
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         frm_q <= '0;
         len_q <= 4'd0;
      end else begin
         frm_q <= frm_d;
         len_q <= len_d;
      end
   end

   assign busy_o = (len_q != 4'd0);
   assign tx_valid_o = (len_q != 4'd0);
   assign tx_data_o = frm_q[0];
endmodule : chl_tx_frame

// *** chl_cmd_parser.sv ***
/*
 * ascii command parser: takes request bytes from the host, checks framing,
 * unit and checksum, answers reads, applies setpoint and offset writes and
 * flags nonvolatile stores; registers over classic wishbone.
 * assumes received bytes arrive as one-cycle strobes on this clock from a
 * uart that cannot be stalled, and that nonvolatile storage acts on the
 * store pulses using the setpoint and offset outputs.
 */
// Added by the designer: the register addresses and the Wishbone slave port.
`include "chl_defines.svh"
module chl_cmd_parser (
   // system
   input wire logic CLOCK_I,
   input wire logic RST_B_I,
   // wishbone slave
   input wire logic WB_CYC_I,
   input wire logic WB_STB_I,
   input wire logic WB_WE_I,
   input wire logic [7:0] WB_ADR_I,
   input wire logic [3:0] WB_SEL_I,
   input wire logic [31:0] WB_DAT_I,
   output logic [31:0] WB_DAT_O,
   output logic WB_ACK_O,
   // received bytes
   input wire logic RX_VALID_I,
   input wire logic [7:0] RX_DATA_I,
   // reply bytes
   output logic TX_VALID_O,
   input wire logic TX_READY_I,
   output logic [7:0] TX_DATA_O,
   // plant values
   input chl_pkg::chl_temp_s INT_TEMP_I,
   input chl_pkg::chl_temp_s EXT_TEMP_I,
   input wire logic [3:0] ALARM_DIGIT_FIRST_I,
   input wire logic [3:0] ALARM_DIGIT_SECOND_I,
   input wire logic [3:0] ALARM_DIGIT_THIRD_I,
   // applied settings and store requests
   output chl_pkg::chl_temp_s SETPOINT_O,
   output chl_pkg::chl_ofs_s OFFSET_O,
   output logic NV_SETPOINT_WR_O,
   output logic NV_OFFSET_WR_O,
   // interrupt
   output logic IRQ_O
);
   import chl_pkg::*;

   // digit conversions
   function automatic logic is_dig(input logic [7:0] b);
      return (b[7:4] == `CHL_HI) && (b[3:0] <= 4'h9);
   endfunction : is_dig

   function automatic logic [3:0][7:0] temp_chars(input chl_temp_s t);
      logic [3:0][7:0] c;
      c[0] = t.neg ? `CHL_MINUS : {`CHL_HI, t.tens};
      c[1] = {`CHL_HI, t.ones};
      c[2] = {`CHL_HI, t.tenths};
      c[3] = {`CHL_HI, t.hund};
      return c;
   endfunction : temp_chars

   function automatic logic [3:0][7:0] ofs_chars(input chl_ofs_s o);
      logic [3:0][7:0] c;
      c[0] = o.neg ? `CHL_MINUS : `CHL_ZERO;
      c[1] = {`CHL_HI, o.ones};
      c[2] = {`CHL_HI, o.tenths};
      c[3] = {`CHL_HI, o.hund};
      return c;
   endfunction : ofs_chars

   // round hundredths into tenths with bcd carry, hundredths then zero
   function automatic chl_temp_s round_tenth(input chl_temp_s t);
      chl_temp_s r;
      r = t;
      r.hund = 4'h0;
      if (t.hund >= 4'h5) begin
         if (t.tenths != 4'h9) begin
            r.tenths = t.tenths + 4'h1;
         end else begin
            r.tenths = 4'h0;
            if (t.ones != 4'h9) begin
               r.ones = t.ones + 4'h1;
            end else begin
               r.ones = 4'h0;
               r.tens = t.tens + 4'h1; // 99.95 carries into tens as Ah and fails the range check
            end
         end
      end
      return r;
   endfunction : round_tenth

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
      logic [31:0] m;
      m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
      return (old & ~m) | (nw & m);
   endfunction : merge

   // register state
   logic [7:0] ctrl_q, ctrl_d;
   logic [`CHL_IRQ_W-1:0] ien_q, ien_d, ist_q, ist_d;
   logic ack_q, ack_d;
   logic [31:0] rdat_q, rdat_d;
   logic wb_req, wb_wr;
   logic [31:0] setp_w, ofs_w;

   // parser state
   chl_rx_e st_q, st_d;
   logic spec_q, spec_d, rd_q, rd_d, csok_q, csok_d;
   logic [7:0] unit_q, unit_d, cmd_q, cmd_d, sum_q, sum_d;
   logic [3:0][7:0] dat_q, dat_d;
   logic [1:0] idx_q, idx_d;
   chl_temp_s setp_q, setp_d, setp_in, setp_rnd;
   chl_ofs_s ofs_q, ofs_d, ofs_in;
   logic nvs_q, nvs_d, nvo_q, nvo_d;
   logic start, tx_busy, unit_ok, ev_done, ev_drop, bad;
   chl_reply_s req;
   logic [7:0] rx;

   assign rx = RX_DATA_I;
   assign wb_req = WB_CYC_I && WB_STB_I;
   // writes take effect on the edge where the master sees ack
   assign wb_wr = wb_req && ack_q && WB_WE_I;
   assign setp_w = merge({16'h0000, setp_q.tens, setp_q.ones, setp_q.tenths, setp_q.hund}, WB_DAT_I, WB_SEL_I);
   assign ofs_w = merge({15'h0000, ofs_q.neg, 4'h0, ofs_q.ones, ofs_q.tenths, ofs_q.hund}, WB_DAT_I, WB_SEL_I);

   // unit-specified frames answer only to our unit character
   assign unit_ok = !spec_q || (unit_q == {`CHL_HI, ctrl_q[7:4]});

   // write payload decoded from received digits
   assign setp_in = '{neg: 1'b0, tens: dat_q[0][3:0], ones: dat_q[1][3:0],
                      tenths: dat_q[2][3:0], hund: dat_q[3][3:0]};
   assign setp_rnd = round_tenth(setp_in);
   assign ofs_in = '{neg: (dat_q[0] == `CHL_MINUS), ones: dat_q[1][3:0],
                     tenths: dat_q[2][3:0], hund: dat_q[3][3:0]};

   // receive state machine, command execution and settings
   always_comb begin
      st_d = st_q;
      spec_d = spec_q;
      rd_d = rd_q;
      csok_d = csok_q;
      unit_d = unit_q;
      cmd_d = cmd_q;
      sum_d = sum_q;
      dat_d = dat_q;
      idx_d = idx_q;
      setp_d = setp_q;
      ofs_d = ofs_q;
      nvs_d = 1'b0;
      nvo_d = 1'b0;
      start = 1'b0;
      ev_drop = 1'b0;
      bad = 1'b0;
      req = '0;
      req.unit_spec = spec_q;
      req.unit_char = unit_q;
      req.cmd = cmd_q;
      if (wb_wr && WB_ADR_I == `CHL_REG_SETP) begin
         setp_d = '{neg: 1'b0, tens: setp_w[15:12], ones: setp_w[11:8], tenths: setp_w[7:4], hund: setp_w[3:0]};
      end
      if (wb_wr && WB_ADR_I == `CHL_REG_OFS) begin
         ofs_d = '{neg: ofs_w[16], ones: ofs_w[11:8], tenths: ofs_w[7:4], hund: ofs_w[3:0]};
      end
      if (RX_VALID_I && ctrl_q[0]) begin
         if (rx == `CHL_SOH) begin
            // start of header restarts the frame from any state
            st_d = RX_UNIT;
            spec_d = 1'b1;
         end else begin
            case (st_q)
               RX_IDLE: begin
                  if (rx == `CHL_ENQ || rx == `CHL_STX) begin
                     st_d = RX_CMD;
                     spec_d = 1'b0;
                     rd_d = (rx == `CHL_ENQ);
                     sum_d = 8'h00;
                  end else if (rx == `CHL_ACK) begin
                     st_d = RX_SKIP;
                  end
               end
               RX_UNIT: begin
                  unit_d = rx;
                  sum_d = rx;
                  st_d = RX_LEAD;
               end
               RX_LEAD: begin
                  if (rx == `CHL_ENQ || rx == `CHL_STX) begin
                     rd_d = (rx == `CHL_ENQ);
                     sum_d = sum_q + rx;
                     st_d = RX_CMD;
                  end else if (rx == `CHL_ACK) begin
                     st_d = RX_IDLE; // unit-specified frames never lead with ACK
                     ev_drop = 1'b1;
                  end else begin
                     st_d = RX_IDLE;
                     ev_drop = 1'b1;
                  end
               end
               RX_CMD: begin
                  cmd_d = rx;
                  sum_d = sum_q + rx;
                  idx_d = 2'd0;
                  st_d = rd_q ? RX_SUMH : RX_DATA;
               end
               RX_DATA: begin
                  dat_d[idx_q] = rx;
                  sum_d = sum_q + rx;
                  idx_d = idx_q + 2'd1;
                  if (idx_q == 2'd3) begin
                     st_d = RX_ETX;
                  end
               end
               RX_ETX: begin
                  st_d = (rx == `CHL_ETX) ? RX_SUMH : RX_IDLE;
                  ev_drop = (rx != `CHL_ETX);
               end
               RX_SUMH: begin
                  csok_d = (rx == {`CHL_HI, sum_q[7:4]});
                  st_d = RX_SUML;
               end
               RX_SUML: begin
                  csok_d = csok_q && (rx == {`CHL_HI, sum_q[3:0]});
                  st_d = RX_END;
               end
               RX_END: begin
                  st_d = RX_IDLE;
                  if (rx != `CHL_CR || !csok_q) begin
                     ev_drop = 1'b1;
                  end else if (!unit_ok) begin
                     // another unit's frame: stay silent
                  end else if (tx_busy) begin
                     ev_drop = 1'b1; // still sending; the host retries
                  end else if (rd_q) begin
                     start = 1'b1;
                     req.n_data = 3'd4;
                     case (cmd_q)
                        `CHL_CMD_SETP: req.data = temp_chars(setp_q);
                        `CHL_CMD_INT: req.data = temp_chars(INT_TEMP_I);
                        `CHL_CMD_EXT: req.data = temp_chars(EXT_TEMP_I);
                        `CHL_CMD_OFS: req.data = ofs_chars(ofs_q);
                        `CHL_CMD_ALM: begin
                           req.n_data = 3'd3;
                           req.data[0] = {`CHL_HI, ALARM_DIGIT_FIRST_I};
                           req.data[1] = {`CHL_HI, ALARM_DIGIT_SECOND_I};
                           req.data[2] = {`CHL_HI, ALARM_DIGIT_THIRD_I};
                        end
                        default: bad = 1'b1;
                     endcase
                  end else begin
                     start = 1'b1;
                     req.is_ack = 1'b1;
                     case (cmd_q)
                        `CHL_CMD_SETP: begin
                           bad = !(is_dig(dat_q[0]) && is_dig(dat_q[1]) && is_dig(dat_q[2]) && is_dig(dat_q[3]));
                           if (!bad) begin
                              setp_d = setp_in;
                           end
                        end
                        `CHL_CMD_OFS, `CHL_CMD_NVOFS: begin
                           bad = !((dat_q[0] == `CHL_MINUS || dat_q[0] == `CHL_ZERO)
                                   && is_dig(dat_q[1]) && is_dig(dat_q[2]) && is_dig(dat_q[3]));
                           if (!bad) begin
                              ofs_d = ofs_in;
                              nvo_d = (cmd_q == `CHL_CMD_NVOFS);
                           end
                        end
                        `CHL_CMD_NVSETP: begin
                           bad = !(is_dig(dat_q[0]) && is_dig(dat_q[1]) && is_dig(dat_q[2]) && is_dig(dat_q[3]))
                                 || (setp_rnd[15:0] < `CHL_SETP_MIN) || (setp_rnd[15:0] > `CHL_SETP_MAX);
                           if (!bad) begin
                              setp_d = setp_rnd;
                              nvs_d = 1'b1;
                           end
                        end
                        default: bad = 1'b1;
                     endcase
                  end
                  if (bad) begin
                     start = 1'b0;
                     ev_drop = 1'b1;
                  end
               end
               RX_SKIP: begin
                  // host acknowledge of our reply carries nothing to act on
                  if (rx == `CHL_CR) begin
                     st_d = RX_IDLE;
                  end
               end
               default: st_d = RX_IDLE;
            endcase
         end
      end
   end
   assign ev_done = start;

   always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         st_q <= RX_IDLE;
         spec_q <= 1'b0;
         rd_q <= 1'b0;
         csok_q <= 1'b0;
         unit_q <= 8'h00;
         cmd_q <= 8'h00;
         sum_q <= 8'h00;
         dat_q <= '0;
         idx_q <= 2'd0;
         setp_q <= {1'b0, `CHL_SETP_RST};
         ofs_q <= '0;
         nvs_q <= 1'b0;
         nvo_q <= 1'b0;
      end else begin
         st_q <= st_d;
         spec_q <= spec_d;
         rd_q <= rd_d;
         csok_q <= csok_d;
         unit_q <= unit_d;
         cmd_q <= cmd_d;
         sum_q <= sum_d;
         dat_q <= dat_d;
         idx_q <= idx_d;
         setp_q <= setp_d;
         ofs_q <= ofs_d;
         nvs_q <= nvs_d;
         nvo_q <= nvo_d;
      end
   end

   // reply framer
   chl_tx_frame u_tx (
      .clk_i(CLOCK_I),
      .rst_b_i(RST_B_I),
      .start_i(start),
      .req_i(req),
      .busy_o(tx_busy),
      .tx_valid_o(TX_VALID_O),
      .tx_ready_i(TX_READY_I),
      .tx_data_o(TX_DATA_O)
   );

   // wishbone slave: ack one cycle after the request, dropped the next
   always_comb begin
      ack_d = wb_req && !ack_q;
      rdat_d = rdat_q;
      ctrl_d = ctrl_q;
      ien_d = ien_q;
      if (wb_req && !ack_q) begin
         case (WB_ADR_I)
            `CHL_REG_CTRL: rdat_d = {24'h000000, ctrl_q};
            `CHL_REG_SETP: rdat_d = {16'h0000, setp_q[15:0]};
            `CHL_REG_OFS: rdat_d = {15'h0000, ofs_q.neg, 4'h0, ofs_q.ones, ofs_q.tenths, ofs_q.hund};
            `CHL_REG_ISTAT: rdat_d = {29'h00000000, ist_q};
            `CHL_REG_IEN: rdat_d = {29'h00000000, ien_q};
            `CHL_REG_STATE: rdat_d = {23'h000000, tx_busy, unit_q[3:0], 4'(st_q)};
            default: rdat_d = 32'h00000000; // clear register and holes read zero
         endcase
      end
      if (wb_wr && WB_ADR_I == `CHL_REG_CTRL && WB_SEL_I[0]) begin
         ctrl_d = WB_DAT_I[7:0];
      end
      if (wb_wr && WB_ADR_I == `CHL_REG_IEN && WB_SEL_I[0]) begin
         ien_d = WB_DAT_I[`CHL_IRQ_W-1:0];
      end
   end

   always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         ack_q <= 1'b0;
         rdat_q <= 32'h00000000;
         ctrl_q <= `CHL_CTRL_RST;
         ien_q <= '0;
      end else begin
         ack_q <= ack_d;
         rdat_q <= rdat_d;
         ctrl_q <= ctrl_d;
         ien_q <= ien_d;
      end
   end

   // sticky events; a new event wins over a clear in the same cycle
   always_comb begin
      ist_d = ist_q;
      if (wb_wr && WB_ADR_I == `CHL_REG_ICLR && WB_SEL_I[0]) begin
         ist_d = ist_q & ~WB_DAT_I[`CHL_IRQ_W-1:0];
      end
      ist_d[`CHL_IRQ_DONE] = ist_d[`CHL_IRQ_DONE] | ev_done;
      ist_d[`CHL_IRQ_DROP] = ist_d[`CHL_IRQ_DROP] | ev_drop;
      ist_d[`CHL_IRQ_NVWR] = ist_d[`CHL_IRQ_NVWR] | nvs_d | nvo_d;
   end

   always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         ist_q <= '0;
      end else begin
         ist_q <= ist_d;
      end
   end

   assign WB_ACK_O = ack_q;
   assign WB_DAT_O = rdat_q;
   assign SETPOINT_O = setp_q;
   assign OFFSET_O = ofs_q;
   assign NV_SETPOINT_WR_O = nvs_q;
   assign NV_OFFSET_WR_O = nvo_q;
   assign IRQ_O = |(ist_q & ien_q);
endmodule : chl_cmd_parser

// *** chl_host_model.sv ***
/* host side byte sink for the parser replies; assumes one clock shared with the parser */
module chl_host_model (
   // clock and pace
   input wire logic clk_i,
   input wire logic slow_i,
   // reply stream
   input wire logic tx_valid_i,
   input wire logic [7:0] tx_data_i,
   output logic tx_ready_o
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] got[$];
   logic ph_q = 1'b0;
   // slow pace takes a byte every other cycle only
   assign tx_ready_o = ~slow_i | ph_q;
   // collect every accepted reply byte
   always @(posedge clk_i) begin
      ph_q <= ~ph_q;
      if (tx_valid_i && tx_ready_o) got.push_back(tx_data_i);
   end
endmodule : chl_host_model

// *** chl_cmd_asserts.sv ***
/* port checker for the parser; assumes it is bound onto the parser by name */
`include "chl_defines.svh"
module chl_cmd_asserts (
   // watched ports, grouped to keep the checker short
   input wire logic CLOCK_I, RST_B_I, WB_CYC_I, WB_STB_I, WB_ACK_O, RX_VALID_I,
   input wire logic TX_VALID_O, TX_READY_I, NV_SETPOINT_WR_O, NV_OFFSET_WR_O,
   input wire logic [7:0] RX_DATA_I,
   input wire logic [7:0] TX_DATA_O,
   input chl_pkg::chl_temp_s SETPOINT_O
);
   timeunit 1ns;
   timeprecision 1ns;
   import chl_pkg::*;
   // one domain, so one clocking and one disable
   default clocking @(posedge CLOCK_I); endclocking
   default disable iff (!RST_B_I);
   a_ack_follows_req: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
      else $error("ack missing");
   a_ack_one_pulse: assert property (WB_ACK_O |=> !WB_ACK_O) else $error("ack too long");
   a_reply_after_cr: assert property ($rose(TX_VALID_O) |-> $past(RX_VALID_I && RX_DATA_I == `CHL_CR))
      else $error("reply without cr");
   a_reply_lead_char: assert property ($rose(TX_VALID_O) |-> TX_DATA_O inside {`CHL_SOH, `CHL_STX, `CHL_ACK})
      else $error("bad lead");
   a_tx_byte_hold: assert property (TX_VALID_O && !TX_READY_I |=> TX_VALID_O && $stable(TX_DATA_O))
      else $error("byte lost");
   a_nv_sp_range: assert property (NV_SETPOINT_WR_O |-> SETPOINT_O[15:0] >= `CHL_SETP_MIN
      && SETPOINT_O[15:0] <= `CHL_SETP_MAX) else $error("setpoint range");
   a_nv_sp_tenth: assert property (NV_SETPOINT_WR_O |-> SETPOINT_O.hund == 4'h0)
      else $error("not rounded");
   a_nv_sp_after_cr: assert property ($rose(NV_SETPOINT_WR_O) |-> $past(RX_VALID_I && RX_DATA_I == `CHL_CR))
      else $error("store timing");
   a_nv_ofs_pulse: assert property (NV_OFFSET_WR_O |=> !NV_OFFSET_WR_O [*2]) else $error("store long");
   c_stall: cover property (TX_VALID_O && !TX_READY_I);
   c_nv_sp: cover property ($rose(NV_SETPOINT_WR_O));
   c_nv_ofs: cover property ($rose(NV_OFFSET_WR_O));
endmodule : chl_cmd_asserts
bind chl_cmd_parser chl_cmd_asserts u_chk (.*);

// *** testbench.sv ***
/* self-checking bench for the parser; assumes the host model and checker are compiled first */
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   import chl_pkg::*;
   logic CLOCK_I = 0, RST_B_I = 0, cyc = 0, we = 0, rxv = 0, slow = 0, rdy;
   logic [7:0] adr = 0, rxd = 0;
   logic [3:0] a1 = 0, a2 = 0, a3 = 0;
   logic [31:0] wd = 0, r;
   chl_temp_s it = 0, et = 0, sp;
   chl_ofs_s of;
   logic [7:0] q[$];
   int err_count = 0, checks = 0, nvs = 0, nvo = 0, n0;
   wire ack, irq, txv, nvsw, nvow;
   wire [7:0] txd;
   wire [31:0] rd;
   chl_cmd_parser dut (.CLOCK_I(CLOCK_I), .RST_B_I(RST_B_I), .WB_CYC_I(cyc), .WB_STB_I(cyc), .WB_WE_I(we),
      .WB_ADR_I(adr), .WB_SEL_I(4'hF), .WB_DAT_I(wd), .WB_DAT_O(rd), .WB_ACK_O(ack), .RX_VALID_I(rxv),
      .RX_DATA_I(rxd), .TX_VALID_O(txv), .TX_READY_I(rdy), .TX_DATA_O(txd), .INT_TEMP_I(it), .EXT_TEMP_I(et),
      .ALARM_DIGIT_FIRST_I(a1), .ALARM_DIGIT_SECOND_I(a2), .ALARM_DIGIT_THIRD_I(a3), .SETPOINT_O(sp),
      .OFFSET_O(of), .NV_SETPOINT_WR_O(nvsw), .NV_OFFSET_WR_O(nvow), .IRQ_O(irq));
   chl_host_model host (.clk_i(CLOCK_I), .slow_i(slow), .tx_valid_i(txv), .tx_data_i(txd), .tx_ready_o(rdy));
   always #4 CLOCK_I = ~CLOCK_I;
   // store pulse counters
   always @(posedge CLOCK_I) begin
      nvs += nvsw;
      nvo += nvow;
   end
   task chk(input logic [31:0] g, e);
      checks++;
      if (g !== e) begin
         err_count++;
         $display("BAD %0t got %h exp %h", $time, g, e);
      end
   endtask : chk
   // classic single cycle, released once ack is seen or after 50 cycles without it
   task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      cyc <= 1;
      we <= w;
      adr <= a;
      wd <= d;
      do @(posedge CLOCK_I); while (ack !== 1'b1 && ++n < 50);
      r = rd;
      cyc <= 0;
      chk(n < 50, 1);
      @(posedge CLOCK_I);
   endtask : wb
   task put(input logic [7:0] b);
      rxv <= 1;
      rxd <= b;
      @(posedge CLOCK_I);
      rxv <= 0;
      @(posedge CLOCK_I);
   endtask : put
   // frame with checksum; unit 0 means no unit
   task mk(input logic [7:0] u, l, c, input int n, input logic [31:0] d);
      logic [7:0] s;
      s = c + ((u != 0) ? u + l : 8'h00);
      q = {};
      if (u != 0) q = {8'h01, u};
      q.push_back(l);
      q.push_back(c);
      for (int i = 0; i < n; i++) begin
         q.push_back(d[31 - 8 * i -: 8]);
         s += d[31 - 8 * i -: 8];
      end
      if (l == 8'h02) q.push_back(8'h03);
      q.push_back({4'h3, s[7:4]});
      q.push_back({4'h3, s[3:0]});
      q.push_back(8'h0D);
   endtask : mk
   task xf(input logic [7:0] u, l, c, input int n, input logic [31:0] d, input logic bad);
      mk(u, l, c, n, d);
      if (bad) q[q.size() - 2] ^= 8'h01;
      host.got = {};
      foreach (q[i]) put(q[i]);
      repeat (40) @(posedge CLOCK_I);
   endtask : xf
   task cq;
      chk(host.got.size(), q.size());
      foreach (q[i]) chk(host.got[i], q[i]);
   endtask : cq
   task t_regs;
      wb(0, 8'h00, 0);
      chk(r, 32'h11);
      wb(0, 8'hFC, 0);
      chk(r, 0);
   endtask : t_regs
   task t_ext;
      et <= {1'b1, 4'h0, 4'h1, 4'h2, 4'h7};
      it <= {1'b0, 4'h2, 4'h5, 4'h0, 4'h2};
      xf(0, 8'h05, 8'h32, 0, 0, 0);
      mk(0, 8'h02, 8'h32, 4, 32'h32353032);
      cq;
      xf(0, 8'h05, 8'h33, 0, 0, 0);
      mk(0, 8'h02, 8'h33, 4, 32'h2D313237);
      cq;
      put(8'h06);
      put(8'h0D);
   endtask : t_ext
   task t_alarm;
      slow <= 1;
      {a1, a2, a3} <= {4'h5, 4'h8, 4'h3};
      xf(8'h31, 8'h05, 8'h34, 0, 0, 0);
      mk(8'h31, 8'h02, 8'h34, 3, 32'h35383300);
      cq;
      slow <= 0;
   endtask : t_alarm
   task t_setp;
      xf(8'h32, 8'h02, 8'h31, 4, 32'h31323334, 0);
      chk(host.got.size(), 0);
      chk(sp, 17'h02500);
      xf(8'h31, 8'h02, 8'h31, 4, 32'h31323334, 0);
      q = {8'h06, 8'h31, 8'h0D};
      cq;
      chk(sp, 17'h01234);
      wb(0, 8'h04, 0);
      chk(r, 32'h1234);
      xf(0, 8'h05, 8'h31, 0, 0, 0);
      mk(0, 8'h02, 8'h31, 4, 32'h31323334);
      cq;
   endtask : t_setp
   task t_nv;
      n0 = nvs;
      xf(0, 8'h02, 8'h37, 4, 32'h32353036, 0);
      chk(sp, 17'h02510);
      chk(nvs - n0, 1);
   endtask : t_nv
   task t_ofs;
      n0 = nvo;
      xf(0, 8'h02, 8'h38, 4, 32'h2D313532, 0);
      chk(of, 13'h1152);
      xf(0, 8'h05, 8'h36, 0, 0, 0);
      mk(0, 8'h02, 8'h36, 4, 32'h2D313532);
      cq;
      xf(0, 8'h02, 8'h36, 4, 32'h30303035, 0);
      q = {8'h06, 8'h0D};
      cq;
      chk(of, 13'h0005);
      chk(nvo - n0, 1);
   endtask : t_ofs
   task t_drop;
      wb(1, 8'h14, 2);
      xf(0, 8'h02, 8'h37, 4, 32'h36303130, 0);
      chk(host.got.size(), 0);
      chk(irq, 1);
      wb(0, 8'h0C, 0);
      chk(r[1], 1);
      wb(1, 8'h10, 2);
      repeat (2) @(posedge CLOCK_I);
      chk(irq, 0);
      xf(0, 8'h05, 8'h33, 0, 0, 1);
      chk(host.got.size(), 0);
      chk(irq, 1);
   endtask : t_drop
   task stop_test;
      $display("checks %0d errors %0d", checks, err_count);
      if (err_count == 0 && checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : stop_test
   // reset held three cycles, then the scenarios
   initial begin
      repeat (3) @(posedge CLOCK_I);
      RST_B_I <= 1;
      @(posedge CLOCK_I);
      t_regs;
      t_ext;
      t_alarm;
      t_setp;
      t_nv;
      t_ofs;
      t_drop;
      stop_test;
   end
   // watchdog at 12500 cycles, well beyond the several hundred cycles needed
   initial begin
      #100000;
      err_count++;
      stop_test;
   end
endmodule : testbench
